//--- temp_monitor_twowire_regs.sv
/*
  Two-wire slave port and register file of a local plus remote
  temperature monitor. Assumes scl_i/sda_i come straight from pins
  (another clock domain), temperature results and status flags come
  from same-clock conversion logic, and an outside pad resolves SDA
  from sda_drive_n_o (low = pull low). SCL is never stretched.
*/
`timescale 1ns/1ps
`include "tmon_map.svh"

module temp_monitor_twowire_regs #(
  parameter int TIMEOUT_CYCLES = `TMON_TIMEOUT_CYC,
  parameter logic [7:0] MAKER_ID = 8'h3c // arbitrary value
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_drive_n_o,
  input wire logic [1:0] addr_pin_zero_i,
  input wire logic [1:0] addr_pin_one_i,
  input wire logic [11:0] local_temp_i,
  input wire logic [11:0] remote_temp_i,
  input wire logic temp_valid_i,
  input wire logic [7:0] status_i,
  output logic status_read_o,
  output logic one_shot_o,
  output logic soft_reset_o,
  output logic hs_mode_o,
  output logic [7:0] device_setup_o,
  output logic [3:0] rate_code_o,
  output logic [7:0] local_upper_limit_o,
  output logic [7:0] local_lower_limit_o,
  output logic [11:0] remote_upper_limit_o,
  output logic [11:0] remote_lower_limit_o,
  output logic [11:0] remote_correction_field_o,
  output logic [1:0] sensor_select_o,
  output logic [7:0] remote_shutdown_limit_o,
  output logic [7:0] local_shutdown_limit_o,
  output logic [7:0] hysteresis_field_o,
  output logic [2:0] violation_count_field_o,
  output logic [7:0] ideality_field_o,
  output logic [1:0] filter_level_field_o
);

  localparam int NPIN = 6;
  localparam int NSLOT = 17;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts once 2nd and 3rd
  // agree, which also rejects one-sample glitches
  logic [NPIN-1:0] raw;
  logic [NPIN-1:0] s1_ff;
  logic [NPIN-1:0] s2_ff;
  logic [NPIN-1:0] s3_ff;
  logic [NPIN-1:0] filt_ff;

  assign raw = {addr_pin_one_i, addr_pin_zero_i, sda_i, scl_i};

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          s1_ff[gp] <= 1'b1;
          s2_ff[gp] <= 1'b1;
          s3_ff[gp] <= 1'b1;
          filt_ff[gp] <= 1'b1;
        end else if (ce_i) begin
          s1_ff[gp] <= raw[gp];
          s2_ff[gp] <= s1_ff[gp];
          s3_ff[gp] <= s2_ff[gp];
          if (s2_ff[gp] == s3_ff[gp]) begin
            filt_ff[gp] <= s3_ff[gp];
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // bus events from the filtered lines
  logic scl_q_ff;
  logic sda_q_ff;
  wire scl_s = filt_ff[0];
  wire sda_s = filt_ff[1];
  wire scl_rise = scl_s & ~scl_q_ff;
  wire scl_fall = ~scl_s & scl_q_ff;
  wire bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  wire bus_stop = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else if (ce_i) begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  // own address from the three-state pins: base plus 3*one + zero
  wire [3:0] pin_one_v = (filt_ff[5:4] == `TMON_PIN_GND) ? 4'h0 :
                         (filt_ff[5:4] == `TMON_PIN_FLOAT) ? 4'h1 : 4'h2;
  wire [3:0] pin_zero_v = (filt_ff[3:2] == `TMON_PIN_GND) ? 4'h0 :
                          (filt_ff[3:2] == `TMON_PIN_FLOAT) ? 4'h1 : 4'h2;
  wire [3:0] addr_idx = 4'(pin_one_v * `TMON_PIN_MULT) + pin_zero_v;
  wire [6:0] own_addr = `TMON_ADDR_BASE + {3'h0, addr_idx}; // R23

  //////////////////////////////////////////////////////////////////////
  // register decode
  function automatic tmon_pkg::slot_e wr_slot(input logic [7:0] p);
    unique case (p)
      `TMON_WR_SETUP: wr_slot = tmon_pkg::SL_SETUP;
      `TMON_WR_RATE: wr_slot = tmon_pkg::SL_RATE;
      `TMON_WR_LHL: wr_slot = tmon_pkg::SL_LHL; // R18
      `TMON_WR_LLL: wr_slot = tmon_pkg::SL_LLL; // R18
      `TMON_WR_RHL: wr_slot = tmon_pkg::SL_RHL; // R19
      `TMON_WR_RLL: wr_slot = tmon_pkg::SL_RLL; // R19
      default: wr_slot = rw_slot(p);
    endcase
  endfunction

  // pointers that read and write the same location
  function automatic tmon_pkg::slot_e rw_slot(input logic [7:0] p);
    unique case (p)
      `TMON_RW_OFSH: rw_slot = tmon_pkg::SL_OFSH; // R20
      `TMON_RW_OFSL: rw_slot = tmon_pkg::SL_OFSL; // R20
      `TMON_RW_RHLL: rw_slot = tmon_pkg::SL_RHLL; // R19
      `TMON_RW_RLLL: rw_slot = tmon_pkg::SL_RLLL; // R19
      `TMON_RW_CHAN: rw_slot = tmon_pkg::SL_CHAN;
      `TMON_RW_RTHM: rw_slot = tmon_pkg::SL_RTHM; // R21
      `TMON_RW_LTHM: rw_slot = tmon_pkg::SL_LTHM; // R21
      `TMON_RW_HYS: rw_slot = tmon_pkg::SL_HYS; // R21
      `TMON_RW_CONAL: rw_slot = tmon_pkg::SL_CONAL;
      `TMON_RW_NFAC: rw_slot = tmon_pkg::SL_NFAC;
      `TMON_RW_FILT: rw_slot = tmon_pkg::SL_FILT; // R22
      default: rw_slot = tmon_pkg::SL_NONE;
    endcase
  endfunction

  function automatic logic [7:0] por_of(input int s);
    unique case (s)
      tmon_pkg::SL_RATE: por_of = `TMON_POR_RATE;
      tmon_pkg::SL_LHL, tmon_pkg::SL_RHL: por_of = `TMON_POR_LIM_HI;
      tmon_pkg::SL_RTHM, tmon_pkg::SL_LTHM: por_of = `TMON_POR_LIM_HI;
      tmon_pkg::SL_LLL, tmon_pkg::SL_RLL: por_of = `TMON_POR_LIM_LO;
      tmon_pkg::SL_RHLL: por_of = `TMON_POR_RHLL;
      tmon_pkg::SL_CHAN: por_of = `TMON_POR_CHAN;
      tmon_pkg::SL_HYS: por_of = `TMON_POR_HYS;
      tmon_pkg::SL_CONAL: por_of = `TMON_POR_CONAL;
      default: por_of = `TMON_POR_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] mask_of(input int s);
    unique case (s)
      tmon_pkg::SL_SETUP: mask_of = `TMON_MSK_SETUP;
      tmon_pkg::SL_RATE: mask_of = `TMON_MSK_RATE;
      tmon_pkg::SL_OFSL, tmon_pkg::SL_RHLL: mask_of = `TMON_MSK_NIB;
      tmon_pkg::SL_RLLL: mask_of = `TMON_MSK_NIB;
      tmon_pkg::SL_CHAN, tmon_pkg::SL_FILT: mask_of = `TMON_MSK_TWO;
      tmon_pkg::SL_CONAL: mask_of = `TMON_MSK_CONAL;
      default: mask_of = `TMON_MSK_ALL;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // serial engine state
  tmon_pkg::link_state_e state_ff;
  logic [7:0] shift_ff;
  logic [3:0] cnt_ff;
  logic rw_ff;
  logic gc_ff;
  logic first_ff;
  logic hs_ff;
  logic busy_ff;
  logic [7:0] ptr_ff;
  logic [`TMON_TO_W-1:0] to_cnt_ff;
  logic sda_drive_n_ff;
  logic one_shot_ff;
  logic soft_reset_ff;
  logic status_read_ff;
  tmon_pkg::byte_t regs_ff [NSLOT];
  tmon_pkg::byte_t lt_hi_ff;
  tmon_pkg::byte_t lt_lo_ff;
  tmon_pkg::byte_t rt_hi_ff;
  tmon_pkg::byte_t rt_lo_ff;

  // byte-level decisions on the falling edge that ends the 8th bit
  wire byte_done = scl_fall & (cnt_ff == `TMON_BITS);
  wire in_addr = (state_ff == tmon_pkg::ST_ADDR);
  wire in_write = (state_ff == tmon_pkg::ST_WRITE);
  wire addr_hit = in_addr & byte_done & (shift_ff[7:1] == own_addr);
  wire gc_hit = in_addr & byte_done & (shift_ff == `TMON_GCALL); // R13
  wire hs_code = in_addr & byte_done &
                 (shift_ff[7:3] == `TMON_HS_CODE); // R11
  wire wr_byte = in_write & byte_done;
  wire ptr_load = wr_byte & ~gc_ff & first_ff; // R1
  wire reg_write = wr_byte & ~gc_ff & ~first_ff;
  wire gc_reset = wr_byte & gc_ff & first_ff &
                  (shift_ff == `TMON_GC_RESET); // R14
  wire one_shot = reg_write & (ptr_ff == `TMON_WR_ONESHOT); // R16
  tmon_pkg::slot_e w_slot;
  assign w_slot = wr_slot(ptr_ff);
  wire lines_low = busy_ff & (~scl_s | ~sda_s);
  wire timeout = lines_low &
                 (to_cnt_ff == `TMON_TO_W'(TIMEOUT_CYCLES - 1)); // R8

  // read byte chosen by the stored pointer
  tmon_pkg::slot_e r_slot;
  tmon_pkg::byte_t tx_byte;
  assign r_slot = rw_slot(ptr_ff);
  always_comb begin
    unique case (ptr_ff) // R3
      `TMON_RD_LT_HI: tx_byte = lt_hi_ff;
      `TMON_RD_RT_HI: tx_byte = rt_hi_ff;
      `TMON_RD_STAT: tx_byte = status_i;
      `TMON_RD_SETUP: tx_byte = regs_ff[tmon_pkg::SL_SETUP];
      `TMON_RD_RATE: tx_byte = regs_ff[tmon_pkg::SL_RATE];
      `TMON_RD_LHL: tx_byte = regs_ff[tmon_pkg::SL_LHL]; // R18
      `TMON_RD_LLL: tx_byte = regs_ff[tmon_pkg::SL_LLL]; // R18
      `TMON_RD_RHL: tx_byte = regs_ff[tmon_pkg::SL_RHL]; // R19
      `TMON_RD_RLL: tx_byte = regs_ff[tmon_pkg::SL_RLL]; // R19
      `TMON_RD_RT_LO: tx_byte = rt_lo_ff;
      `TMON_RD_LT_LO: tx_byte = lt_lo_ff;
      `TMON_RD_MAKER: tx_byte = MAKER_ID;
      default: tx_byte = (r_slot == tmon_pkg::SL_NONE) ? `TMON_POR_ZERO :
                         regs_ff[r_slot];
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // bus-stuck timeout counter, runs only inside a transaction
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      to_cnt_ff <= '0;
    end else if (ce_i) begin
      to_cnt_ff <= (lines_low & ~timeout) ? to_cnt_ff + 1'b1 : '0; // R8
    end
  end

  //////////////////////////////////////////////////////////////////////
  // serial engine; start, stop and timeout override any bit activity
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_ff <= tmon_pkg::ST_IDLE;
      shift_ff <= '0;
      cnt_ff <= '0;
      rw_ff <= 1'b0;
      gc_ff <= 1'b0;
      first_ff <= 1'b0;
      hs_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (ce_i) begin
      if (timeout) begin
        state_ff <= tmon_pkg::ST_IDLE; // R8
        busy_ff <= 1'b0;
        hs_ff <= 1'b0;
      end else if (bus_stop) begin
        state_ff <= tmon_pkg::ST_IDLE;
        busy_ff <= 1'b0;
        hs_ff <= 1'b0; // R12
      end else if (bus_start) begin
        state_ff <= tmon_pkg::ST_ADDR; // repeated start keeps hs_ff
        cnt_ff <= '0;
        busy_ff <= 1'b1;
      end else begin
        unique case (state_ff)
          tmon_pkg::ST_IDLE: begin
            cnt_ff <= '0;
          end
          tmon_pkg::ST_ADDR, tmon_pkg::ST_WRITE: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_s};
              cnt_ff <= cnt_ff + 1'b1;
            end
            if (addr_hit | gc_hit) begin
              state_ff <= tmon_pkg::ST_ACK;
              rw_ff <= shift_ff[0] & ~gc_hit;
              gc_ff <= gc_hit;
              first_ff <= 1'b1;
            end else if (hs_code) begin
              state_ff <= tmon_pkg::ST_IDLE; // R11
              hs_ff <= 1'b1;
            end else if (wr_byte) begin
              state_ff <= tmon_pkg::ST_ACK; // R24
              first_ff <= 1'b0; // R15
            end else if (in_addr & byte_done) begin
              state_ff <= tmon_pkg::ST_IDLE;
            end
          end
          tmon_pkg::ST_ACK: begin
            cnt_ff <= '0;
            if (scl_fall) begin
              if (rw_ff) begin
                state_ff <= tmon_pkg::ST_READ;
                shift_ff <= tx_byte; // R3
              end else begin
                state_ff <= tmon_pkg::ST_WRITE; // R4
              end
            end
          end
          tmon_pkg::ST_READ: begin
            if (scl_fall) begin
              shift_ff <= {shift_ff[6:0], 1'b0}; // R6
              cnt_ff <= cnt_ff + 1'b1;
              if (cnt_ff == `TMON_LAST_TX) begin
                state_ff <= tmon_pkg::ST_RACK;
              end
            end
          end
          tmon_pkg::ST_RACK: begin
            cnt_ff <= '0;
            if (scl_rise & sda_s) begin
              state_ff <= tmon_pkg::ST_IDLE; // R7
            end else if (scl_fall) begin
              state_ff <= tmon_pkg::ST_READ;
              shift_ff <= tx_byte; // R5
            end
          end
          default: state_ff <= tmon_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // pointer: loaded by the first byte of a write, kept across reads
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ptr_ff <= '0;
    end else if (ce_i) begin
      if (gc_reset) begin
        ptr_ff <= '0; // R14
      end else if (ptr_load) begin
        ptr_ff <= shift_ff; // R1
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // writable registers; bits outside the mask keep their fixed values
  genvar gs;
  generate
    for (gs = 0; gs < NSLOT; gs++) begin : g_reg
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          regs_ff[gs] <= por_of(gs);
        end else if (ce_i) begin
          if (gc_reset) begin
            regs_ff[gs] <= por_of(gs); // R14
          end else if (reg_write && w_slot == gs) begin
            regs_ff[gs] <= (shift_ff & mask_of(gs)) |
                           (por_of(gs) & ~mask_of(gs)); // R24
          end
        end
      end
    end
  endgenerate

  // results: high byte bits 11:4, low byte bits 3:0 in upper nibble
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      lt_hi_ff <= '0;
      lt_lo_ff <= '0;
      rt_hi_ff <= '0;
      rt_lo_ff <= '0;
    end else if (ce_i) begin
      if (gc_reset) begin
        lt_hi_ff <= '0;
        lt_lo_ff <= '0;
        rt_hi_ff <= '0;
        rt_lo_ff <= '0;
      end else if (temp_valid_i) begin
        lt_hi_ff <= local_temp_i[11:4]; // R17
        lt_lo_ff <= {local_temp_i[3:0], 4'h0}; // R17
        rt_hi_ff <= remote_temp_i[11:4];
        rt_lo_ff <= {remote_temp_i[3:0], 4'h0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered pin drive and event pulses; ack and data low only
  wire drive_low = (state_ff == tmon_pkg::ST_ACK) |
                   ((state_ff == tmon_pkg::ST_READ) & ~shift_ff[7]);
  wire stat_load = rw_ff & (ptr_ff == `TMON_RD_STAT) & scl_fall &
                   ((state_ff == tmon_pkg::ST_ACK) |
                    (state_ff == tmon_pkg::ST_RACK));

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sda_drive_n_ff <= 1'b1;
      one_shot_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
      status_read_ff <= 1'b0;
    end else if (ce_i) begin
      sda_drive_n_ff <= ~drive_low | timeout | bus_stop; // R6
      one_shot_ff <= one_shot; // R16
      soft_reset_ff <= gc_reset; // R14
      status_read_ff <= stat_load;
    end
  end

  assign sda_drive_n_o = sda_drive_n_ff;
  assign one_shot_o = one_shot_ff;
  assign soft_reset_o = soft_reset_ff;
  assign status_read_o = status_read_ff;
  assign hs_mode_o = hs_ff; // R12
  assign device_setup_o = regs_ff[tmon_pkg::SL_SETUP];
  assign rate_code_o = regs_ff[tmon_pkg::SL_RATE][3:0];
  assign local_upper_limit_o = regs_ff[tmon_pkg::SL_LHL];
  assign local_lower_limit_o = regs_ff[tmon_pkg::SL_LLL];
  assign remote_upper_limit_o = {regs_ff[tmon_pkg::SL_RHL],
                                 regs_ff[tmon_pkg::SL_RHLL][7:4]};
  assign remote_lower_limit_o = {regs_ff[tmon_pkg::SL_RLL],
                                 regs_ff[tmon_pkg::SL_RLLL][7:4]};
  assign remote_correction_field_o = {regs_ff[tmon_pkg::SL_OFSH],
                                      regs_ff[tmon_pkg::SL_OFSL][7:4]};
  assign sensor_select_o = regs_ff[tmon_pkg::SL_CHAN][1:0];
  assign remote_shutdown_limit_o = regs_ff[tmon_pkg::SL_RTHM];
  assign local_shutdown_limit_o = regs_ff[tmon_pkg::SL_LTHM];
  assign hysteresis_field_o = regs_ff[tmon_pkg::SL_HYS];
  assign violation_count_field_o = regs_ff[tmon_pkg::SL_CONAL][3:1];
  assign ideality_field_o = regs_ff[tmon_pkg::SL_NFAC];
  assign filter_level_field_o = regs_ff[tmon_pkg::SL_FILT][1:0];

  //////////////////////////////////////////////////////////////////////
  // checks
  a_ptr_load: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ce_i && ptr_load |=> ptr_ff == $past(shift_ff)) // R1
    else $error("pointer not loaded from first write byte");

  a_ptr_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !(ce_i && (ptr_load || gc_reset)) |=> $stable(ptr_ff)) // R5
    else $error("pointer changed without a write");

  a_tx_msb: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ce_i && state_ff == tmon_pkg::ST_READ && !bus_stop && !timeout
    |=> sda_drive_n_ff == $past(shift_ff[7])) // R6
    else $error("sda does not follow the msb being sent");

  a_timeout_rel: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ce_i && timeout |=> state_ff == tmon_pkg::ST_IDLE && sda_drive_n_ff
    && !busy_ff) // R8
    else $error("timeout did not release the bus");

  a_hs_enter: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ce_i && hs_code && !bus_stop && !bus_start && !timeout
    |=> hs_ff && state_ff == tmon_pkg::ST_IDLE ##1 sda_drive_n_ff) // R11
    else $error("master code mishandled");

  a_hs_exit: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ce_i && bus_stop |=> !hs_ff) // R12
    else $error("high speed kept after stop");

  a_gc_reset: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ce_i && gc_reset |=> soft_reset_o &&
    regs_ff[tmon_pkg::SL_HYS] == `TMON_POR_HYS &&
    regs_ff[tmon_pkg::SL_RATE] == `TMON_POR_RATE) // R14
    else $error("general-call reset did not restore registers");

  a_one_shot: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ce_i && reg_write && ptr_ff == `TMON_WR_ONESHOT
    |=> one_shot_o ##1 !one_shot_o || !ce_i) // R16
    else $error("single conversion pulse wrong");

  a_ro_discard: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ce_i && reg_write && w_slot == tmon_pkg::SL_NONE
    |=> $stable(regs_ff[tmon_pkg::SL_SETUP]) &&
    $stable(regs_ff[tmon_pkg::SL_FILT])) // R24
    else $error("write to read-only pointer changed a register");

endmodule // temp_monitor_twowire_regs

//--- tmon_map.svh
/*
  Constants of the two-wire temperature monitor register port: pointer
  codes, power-on values, write masks, bus codes and timing figures.
  Assumes a 50 MHz device clock and a single including design file.
*/
// Behaviour
// R1 - first write byte after address loads pointer
// R2 - master sends pointer before any data byte
// R3 - reads use pointer last stored by write
// R4 - pointer-only write accepted, then read follows
// R5 - pointer unchanged across reads until next write
// R6 - register byte shifted out MSB first
// R7 - master ends read with not-acknowledge
// R8 - 25 ms low line resets interface, releases
// R9 - master keeps clock at least 1 kHz
// R10 - master sends 0000 1xxx before high speed
// R11 - master code unacknowledged, filters go high-speed
// R12 - high speed lasts until stop condition
// R13 - general call 00h acknowledged, second byte read
// R14 - second byte 06h restores power-on register state
// R15 - other general-call second bytes do nothing
// R16 - write to pointer 0F starts single conversion
// R17 - temperature split into high and low bytes
// R18 - local limits read 05/06, write 0B/0C
// R19 - remote limits 07/08 read, 0D/0E write, 13/14
// R20 - offset at pointers 11 and 12, resets zero
// R21 - shutdown limits 19/20 reset 7F, hysteresis 0A
// R22 - filter level bits 1:0 at pointer 24
// R23 - slave address 48h..50h from two pin states
// R24 - writes to read-only pointers discarded silently
`ifndef TMON_MAP_SVH
`define TMON_MAP_SVH

// read pointers
`define TMON_RD_LT_HI 8'h00
`define TMON_RD_RT_HI 8'h01
`define TMON_RD_STAT 8'h02
`define TMON_RD_SETUP 8'h03
`define TMON_RD_RATE 8'h04
`define TMON_RD_LHL 8'h05
`define TMON_RD_LLL 8'h06
`define TMON_RD_RHL 8'h07
`define TMON_RD_RLL 8'h08
`define TMON_RD_RT_LO 8'h10
`define TMON_RD_LT_LO 8'h15
`define TMON_RD_MAKER 8'hfe
// write pointers
`define TMON_WR_SETUP 8'h09
`define TMON_WR_RATE 8'h0a
`define TMON_WR_LHL 8'h0b
`define TMON_WR_LLL 8'h0c
`define TMON_WR_RHL 8'h0d
`define TMON_WR_RLL 8'h0e
`define TMON_WR_ONESHOT 8'h0f
// pointers shared by read and write
`define TMON_RW_OFSH 8'h11
`define TMON_RW_OFSL 8'h12
`define TMON_RW_RHLL 8'h13
`define TMON_RW_RLLL 8'h14
`define TMON_RW_CHAN 8'h16
`define TMON_RW_RTHM 8'h19
`define TMON_RW_LTHM 8'h20
`define TMON_RW_HYS 8'h21
`define TMON_RW_CONAL 8'h22
`define TMON_RW_NFAC 8'h23
`define TMON_RW_FILT 8'h24
// power-on values
`define TMON_POR_ZERO 8'h00
`define TMON_POR_RATE 8'h08
`define TMON_POR_LIM_HI 8'h7f
`define TMON_POR_LIM_LO 8'h80
`define TMON_POR_RHLL 8'hf0
`define TMON_POR_CHAN 8'h03
`define TMON_POR_HYS 8'h0a
`define TMON_POR_CONAL 8'h01
// writable bits; the rest read back as fixed values
`define TMON_MSK_ALL 8'hff
`define TMON_MSK_SETUP 8'he4
`define TMON_MSK_RATE 8'h0f
`define TMON_MSK_NIB 8'hf0
`define TMON_MSK_TWO 8'h03
`define TMON_MSK_CONAL 8'h0e
`define TMON_FIX_CONAL 8'h01
// bus codes
`define TMON_GCALL 8'h00
`define TMON_GC_RESET 8'h06
`define TMON_HS_CODE 5'h01
`define TMON_ADDR_BASE 7'h48
`define TMON_PIN_GND 2'h0
`define TMON_PIN_FLOAT 2'h1
`define TMON_PIN_MULT 4'h3
`define TMON_BITS 4'h8
`define TMON_LAST_TX 4'h7
// timing: bus-stuck timeout
`define TMON_TIMEOUT_MS 25
`define TMON_CLK_KHZ 50000
`define TMON_TIMEOUT_CYC (`TMON_TIMEOUT_MS * `TMON_CLK_KHZ)
`define TMON_TO_W 21

`endif

//--- tmon_pkg.sv
/*
  Types of the two-wire temperature monitor register port.
  Assumes the constants of tmon_map.svh alongside.
*/
package tmon_pkg;

  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_RACK = 3'b101
  } link_state_e;

  // storage slots of the writable registers
  typedef enum logic [4:0] {
    SL_SETUP = 5'b00000,
    SL_RATE = 5'b00001,
    SL_LHL = 5'b00010,
    SL_LLL = 5'b00011,
    SL_RHL = 5'b00100,
    SL_RLL = 5'b00101,
    SL_OFSH = 5'b00110,
    SL_OFSL = 5'b00111,
    SL_RHLL = 5'b01000,
    SL_RLLL = 5'b01001,
    SL_CHAN = 5'b01010,
    SL_RTHM = 5'b01011,
    SL_LTHM = 5'b01100,
    SL_HYS = 5'b01101,
    SL_CONAL = 5'b01110,
    SL_NFAC = 5'b01111,
    SL_FILT = 5'b10000,
    SL_NONE = 5'b11111
  } slot_e;

  typedef logic [7:0] byte_t;

endpackage

//--- twowire_host.sv
/* Two-wire bus master model: scl and open-drain sda.
   Assumes sda_i is the resolved wire with a pull-up. */
`timescale 1ns/1ps
module twowire_host (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // scl stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // data moves 2 clocks after the fall so it never races scl
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge clock_i);
    sda_o = b;
    repeat (6) @(negedge clock_i);
    scl_o = 1'b1;
    repeat (8) @(negedge clock_i);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  // start or repeated start; leaves scl low
  task automatic start();
    if (!scl_o) begin
      repeat (2) @(negedge clock_i);
      sda_o = 1'b1;
      repeat (6) @(negedge clock_i);
      scl_o = 1'b1;
    end
    repeat (8) @(negedge clock_i);
    sda_o = 1'b0;
    repeat (8) @(negedge clock_i);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(negedge clock_i);
    sda_o = 1'b0;
    repeat (6) @(negedge clock_i);
    scl_o = 1'b1;
    repeat (8) @(negedge clock_i);
    sda_o = 1'b1;
    repeat (8) @(negedge clock_i);
  endtask
  // byte MSB first, then the ninth slot left released
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    ack = ~a;
  endtask
endmodule // twowire_host

//--- temp_monitor_twowire_regs_tb_top.sv
/* Bench of the two-wire temperature monitor port.
   Assumes twowire_host as bus master and a pull-up on sda. */
`timescale 1ns/1ps
module temp_monitor_twowire_regs_tb_top;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic temp_valid_i = 1'b0;
  logic [11:0] temp = 12'habc;
  logic scl, sda_m, sda_drive_n_o, one_shot_o, soft_reset_o, hs_mode_o;
  logic [7:0] q;
  logic ack;
  int errors = 0;
  int n_tests = 0;
  int shots = 0;
  int resets = 0;
  wire sda = sda_m & sda_drive_n_o;
  always #10 clock_i = ~clock_i;
  // pulses are only one cycle wide, so count them
  always @(posedge clock_i) begin
    shots <= shots + int'(one_shot_o === 1'b1);
    resets <= resets + int'(soft_reset_o === 1'b1);
  end
  twowire_host u_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
    .sda_o(sda_m));
  temp_monitor_twowire_regs #(.TIMEOUT_CYCLES(2000), .MAKER_ID(8'h5e)) u_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1), .scl_i(scl),
    .sda_i(sda), .sda_drive_n_o(sda_drive_n_o), .addr_pin_zero_i(2'h0),
    .addr_pin_one_i(2'h0), .local_temp_i(temp), .remote_temp_i(temp),
    .temp_valid_i(temp_valid_i), .status_i(8'ha5), .status_read_o(),
    .one_shot_o(one_shot_o), .soft_reset_o(soft_reset_o),
    .hs_mode_o(hs_mode_o), .device_setup_o(), .rate_code_o(),
    .local_upper_limit_o(), .local_lower_limit_o(),
    .remote_upper_limit_o(), .remote_lower_limit_o(),
    .remote_correction_field_o(), .sensor_select_o(),
    .remote_shutdown_limit_o(), .local_shutdown_limit_o(),
    .hysteresis_field_o(), .violation_count_field_o(),
    .ideality_field_o(), .filter_level_field_o());
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic send(input logic [7:0] d, input logic a);
    u_host.xfer(d, q, ack);
    check({7'h00, ack}, {7'h00, a});
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_host.start();
    send(8'h90, 1'b1);
    send(p, 1'b1);
    send(d, 1'b1);
    u_host.stop();
  endtask
  // re-point with a data-less write, then read after a repeated start
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    u_host.start();
    send(8'h90, 1'b1);
    send(p, 1'b1);
    u_host.start();
    send(8'h91, 1'b1);
    u_host.xfer(8'hff, q, ack);
    check(q, e);
    u_host.stop();
  endtask
  task automatic t_por();
    logic [7:0] p[10] = '{8'h04, 8'h05, 8'h06, 8'h13, 8'h21, 8'h22,
      8'h24, 8'h02, 8'h16, 8'hfe};
    logic [7:0] e[10] = '{8'h08, 8'h7f, 8'h80, 8'hf0, 8'h0a, 8'h01,
      8'h00, 8'ha5, 8'h03, 8'h5e};
    for (int i = 0; i < 10; i++) rd(p[i], e[i]);
    $display("power-on test done");
  endtask
  task automatic t_regs();
    int s0;
    temp_valid_i = 1'b1;
    @(negedge clock_i) temp_valid_i = 1'b0;
    rd(8'h00, 8'hab);
    rd(8'h10, 8'hc0);
    rd(8'h15, 8'hc0);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hab);
    wr(8'h0b, 8'h5a);
    rd(8'h05, 8'h5a);
    u_host.start();
    send(8'h91, 1'b1);
    u_host.xfer(8'hff, q, ack);
    check(q, 8'h5a);
    u_host.stop();
    wr(8'h0d, 8'h12);
    rd(8'h07, 8'h12);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'hf0);
    s0 = shots;
    wr(8'h0f, 8'h33);
    check(8'(shots - s0), 8'h01);
    $display("register test done");
  endtask
  task automatic t_gcall();
    int r0;
    r0 = resets;
    for (int i = 0; i < 2; i++) begin
      u_host.start();
      send(8'h00, 1'b1);
      send(i ? 8'h06 : 8'h07, 1'b1);
      u_host.stop();
      rd(8'h05, i ? 8'h7f : 8'h5a);
    end
    check(8'(resets - r0), 8'h01);
    $display("general call test done");
  endtask
  task automatic t_hs();
    u_host.start();
    send(8'h08, 1'b0);
    check({7'h00, hs_mode_o}, 8'h01);
    u_host.start();
    send(8'h90, 1'b1);
    check({7'h00, hs_mode_o}, 8'h01);
    u_host.stop();
    repeat (8) @(negedge clock_i);
    check({7'h00, hs_mode_o}, 8'h00);
    $display("high-speed test done");
  endtask
  // scl parked low while the device drives a low data bit
  task automatic t_timeout();
    rd(8'h05, 8'h7f);
    u_host.start();
    send(8'h91, 1'b1);
    repeat (100) @(negedge clock_i);
    check({7'h00, sda_drive_n_o}, 8'h00);
    repeat (2100) @(negedge clock_i);
    check({7'h00, sda_drive_n_o}, 8'h01);
    u_host.stop();
    rd(8'h05, 8'h7f);
    $display("timeout test done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clock_i);
    t_por();
    t_regs();
    t_gcall();
    t_hs();
    t_timeout();
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clock_i);
    errors++;
    complete_run();
  end
endmodule // temp_monitor_twowire_regs_tb_top
